// File: umi_modem_ir.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
// Function
// - In infrared mode the serial output carries the encoded transmit stream, else plain.
// - In infrared mode the serial input is pulse decoded before the receiver, else direct.
// - A programmable-rate serial clock is driven on its own output pin.
// - Setting the request-to-send control bit drives request-to-send low.
// - Reset forces request-to-send high.
// - Setting the terminal-ready control bit drives terminal-ready low.
// - Reset forces terminal-ready high.
// - Loop mode holds request-to-send and terminal-ready high.
// - Set-ready status bit reads as complement of the set-ready pin.
// - Set-ready delta sets when the pin changed since the last status read.
// - Carrier status bit reads as complement of the carrier-detect pin.
// - Carrier delta sets when the pin changed since the last status read.
// - Clear-to-send status bit reads as complement of the clear-to-send pin.
// - Clear-to-send delta sets when the pin changed since the last status read.
// - Carrier-detect is status only and never touches the receive path.
// - Clear-to-send is status only and never touches the transmit path.
// - Enabled modem status interrupt fires on any delta bit.
// - Ring status bit reads as complement of the ring-indicator pin.
// - Ring trailing-edge bit sets on a low-to-high ring pin change, and interrupts.
module umi_modem_ir (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       bit_x16_en,
  input  wire logic       tx_data,
  output logic            rx_data,
  output logic            serial_out,
  input  wire logic       serial_in,
  output logic            serial_rate_clock_out,
  output logic            request_to_send_n,
  output logic            terminal_ready_n,
  input  wire logic       set_ready_n,
  input  wire logic       carrier_detect_n,
  input  wire logic       clear_to_send_n,
  input  wire logic       ring_indicator_n,
  output logic            modem_status_irq
);

  logic [7:0] ie_q;
  logic [7:0] ie_d;
  logic [7:0] mctl_q;
  logic [7:0] mctl_d;
  logic [7:0] irctl_q;
  logic [7:0] irctl_d;
  logic [7:0] cdiv_q;
  logic [7:0] cdiv_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [3:0] pins_q;
  logic [3:0] delta_q;
  logic [3:0] delta_d;
  logic [7:0] div_cnt_q;
  logic [7:0] div_cnt_d;
  logic       rate_clk_q;
  logic [3:0] enc_cnt_q;
  logic [3:0] enc_cnt_d;
  logic       tx_prev_q;
  logic [4:0] dec_cnt_q;
  logic [4:0] dec_cnt_d;
  logic       in_prev_q;
  logic       serial_out_q;
  logic       rx_data_q;

  // Pin vector order: clear-to-send, set-ready, ring, carrier.
  wire [3:0] pins_now  = {carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n};
  wire       wr_ie     = reg_wr && (reg_addr == umi_pkg::UMI_ADDR_IE);
  wire       wr_mctl   = reg_wr && (reg_addr == umi_pkg::UMI_ADDR_MCTL);
  wire       wr_irctl  = reg_wr && (reg_addr == umi_pkg::UMI_ADDR_IRCTL);
  wire       wr_cdiv   = reg_wr && (reg_addr == umi_pkg::UMI_ADDR_CDIV);
  wire       rd_mstat  = reg_rd && (reg_addr == umi_pkg::UMI_ADDR_MSTAT);
  wire       ir_mode   = irctl_q[umi_pkg::UMI_IRCTL_EN];
  wire       loop_mode = mctl_q[umi_pkg::UMI_MCTL_LOOP];

  // Change detection; a ring change counts only from low to high.
  wire [3:0] delta_set = {pins_now[3] ^ pins_q[3],
                          pins_now[2] & ~pins_q[2],
                          pins_now[1] ^ pins_q[1],
                          pins_now[0] ^ pins_q[0]};

  // Status image: upper nibble is the inverted pins, lower nibble the deltas.
  wire [7:0] mstat_img;
  assign mstat_img[umi_pkg::UMI_MS_CARR]   = ~carrier_detect_n;
  assign mstat_img[umi_pkg::UMI_MS_RING]   = ~ring_indicator_n;
  assign mstat_img[umi_pkg::UMI_MS_SETR]   = ~set_ready_n;
  assign mstat_img[umi_pkg::UMI_MS_CLR]    = ~clear_to_send_n;
  assign mstat_img[umi_pkg::UMI_MS_DCARR]  = delta_q[3];
  assign mstat_img[umi_pkg::UMI_MS_RTRAIL] = delta_q[2];
  assign mstat_img[umi_pkg::UMI_MS_DSETR]  = delta_q[1];
  assign mstat_img[umi_pkg::UMI_MS_DCLR]   = delta_q[0];

  setr_pin_a: assert property (@(posedge clk) disable iff (rst)
    rd_mstat |=> (reg_rdata[umi_pkg::UMI_MS_SETR] == !$past(set_ready_n)))
    else $error("Set-ready status bit does not mirror the inverted pin.");

  carr_pin_a: assert property (@(posedge clk) disable iff (rst)
    rd_mstat |=> (reg_rdata[umi_pkg::UMI_MS_CARR] == !$past(carrier_detect_n)))
    else $error("Carrier status bit does not mirror the inverted pin.");

  clr_pin_a: assert property (@(posedge clk) disable iff (rst)
    rd_mstat |=> (reg_rdata[umi_pkg::UMI_MS_CLR] == !$past(clear_to_send_n)))
    else $error("Clear-to-send status bit does not mirror the inverted pin.");

  ring_pin_a: assert property (@(posedge clk) disable iff (rst)
    rd_mstat |=> (reg_rdata[umi_pkg::UMI_MS_RING] == !$past(ring_indicator_n)))
    else $error("Ring status bit does not mirror the inverted pin.");

  // An event in the cycle of a status read survives: set wins over clear.
  assign delta_d = delta_set | (rd_mstat ? 4'h0 : delta_q);

  setr_hold_a: assert property (@(posedge clk) disable iff (rst)
    (delta_q[1] && !rd_mstat) |=> delta_q[1])
    else $error("Set-ready delta lost before a status read.");

  carr_hold_a: assert property (@(posedge clk) disable iff (rst)
    (delta_q[3] && !rd_mstat) |=> delta_q[3])
    else $error("Carrier delta lost before a status read.");

  clr_hold_a: assert property (@(posedge clk) disable iff (rst)
    (delta_q[0] && !rd_mstat) |=> delta_q[0])
    else $error("Clear-to-send delta lost before a status read.");

  ring_hold_a: assert property (@(posedge clk) disable iff (rst)
    (delta_q[2] && !rd_mstat) |=> delta_q[2])
    else $error("Ring trailing-edge bit lost before a status read.");

  delta_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (delta_set == 4'h0 && delta_q == 4'h0) |=> (delta_q == 4'h0))
    else $error("Delta bit set without a pin change.");

  ring_fall_a: assert property (@(posedge clk) disable iff (rst)
    (!ring_indicator_n && pins_q[2] && !delta_q[2]) |=> !delta_q[2])
    else $error("Ring trailing-edge bit set on a falling ring pin.");

  read_delta_a: assert property (@(posedge clk) disable iff (rst)
    rd_mstat |=> (reg_rdata[3:0] == $past(delta_q)))
    else $error("Status read does not show the pending deltas.");

  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    (rd_mstat && delta_set != 4'h0) |=> (delta_q == $past(delta_set)))
    else $error("Change during a status read was lost.");

  assign ie_d    = wr_ie ? reg_wdata : ie_q;
  assign mctl_d  = wr_mctl ? reg_wdata : mctl_q;
  assign irctl_d = wr_irctl ? reg_wdata : irctl_q;
  assign cdiv_d  = wr_cdiv ? reg_wdata : cdiv_q;

  // Unmapped addresses read as zero.
  assign rdata_d = !reg_rd ? umi_pkg::UMI_RDATA_RST :
                   (reg_addr == umi_pkg::UMI_ADDR_IE)    ? ie_q :
                   (reg_addr == umi_pkg::UMI_ADDR_MCTL)  ? mctl_q :
                   (reg_addr == umi_pkg::UMI_ADDR_MSTAT) ? mstat_img :
                   (reg_addr == umi_pkg::UMI_ADDR_IRCTL) ? irctl_q :
                   (reg_addr == umi_pkg::UMI_ADDR_CDIV)  ? cdiv_q : umi_pkg::UMI_RDATA_RST;

  always_ff @(posedge clk) begin
    if (rst) begin
      ie_q    <= umi_pkg::UMI_IE_RST;
      mctl_q  <= umi_pkg::UMI_MCTL_RST;
      irctl_q <= umi_pkg::UMI_IRCTL_RST;
      cdiv_q  <= umi_pkg::UMI_CDIV_RST;
      rdata_q <= umi_pkg::UMI_RDATA_RST;
      delta_q <= 4'h0;
      pins_q  <= 4'hF;
    end else begin
      ie_q    <= ie_d;
      mctl_q  <= mctl_d;
      irctl_q <= irctl_d;
      cdiv_q  <= cdiv_d;
      rdata_q <= rdata_d;
      delta_q <= delta_d;
      pins_q  <= pins_now;
    end
  end

  assign reg_rdata = rdata_q;

  // Handshake outputs follow the control register directly, so a cleared bit shows at the write edge.
  assign request_to_send_n = ~(mctl_q[umi_pkg::UMI_MCTL_RTS] & ~loop_mode);
  assign terminal_ready_n  = ~(mctl_q[umi_pkg::UMI_MCTL_TREADY] & ~loop_mode);

  rts_stable_a: assert property (@(posedge clk) disable iff (rst)
    !wr_mctl |=> $stable(request_to_send_n))
    else $error("Request-to-send moved without a control write.");

  tready_stable_a: assert property (@(posedge clk) disable iff (rst)
    !wr_mctl |=> $stable(terminal_ready_n))
    else $error("Terminal-ready moved without a control write.");

  rts_clear_a: assert property (@(posedge clk) disable iff (rst)
    (wr_mctl && !reg_wdata[umi_pkg::UMI_MCTL_RTS]) |=> request_to_send_n)
    else $error("Request-to-send not released after its bit was cleared.");

  tready_clear_a: assert property (@(posedge clk) disable iff (rst)
    (wr_mctl && !reg_wdata[umi_pkg::UMI_MCTL_TREADY]) |=> terminal_ready_n)
    else $error("Terminal-ready not released after its bit was cleared.");

  assign modem_status_irq = ie_q[umi_pkg::UMI_IE_MSTAT] & (|delta_q);

  irq_off_a: assert property (@(posedge clk) disable iff (rst)
    !ie_q[umi_pkg::UMI_IE_MSTAT] |-> !modem_status_irq)
    else $error("Modem status interrupt raised while disabled.");

  irq_src_a: assert property (@(posedge clk) disable iff (rst)
    modem_status_irq |-> (delta_q != 4'h0))
    else $error("Modem status interrupt raised with no delta pending.");

  // Rate clock: it toggles every divisor plus one clocks, so a divisor of zero toggles it every clock and the pin never freezes.
  wire div_hit = (div_cnt_q >= cdiv_q);
  assign div_cnt_d = div_hit ? 8'h00 : div_cnt_q + 8'h01;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_q  <= 8'h00;
      rate_clk_q <= 1'b0;
    end else begin
      div_cnt_q  <= div_cnt_d;
      rate_clk_q <= div_hit ? ~rate_clk_q : rate_clk_q;
    end
  end

  assign serial_rate_clock_out = rate_clk_q;

  rate_hold_a: assert property (@(posedge clk) disable iff (rst)
    !div_hit |=> $stable(serial_rate_clock_out))
    else $error("Rate clock moved between divider terminal counts.");

  // Encoder: each zero bit cell carries a high pulse of three sixteenths; cells are aligned to data edges.
  wire tx_edge   = tx_data ^ tx_prev_q;
  assign enc_cnt_d = tx_edge ? 4'h0 : (bit_x16_en ? enc_cnt_q + 4'h1 : enc_cnt_q);
  wire ir_pulse  = ~tx_data & (enc_cnt_q < umi_pkg::UMI_IR_PULSE_TICKS);

  // Decoder: each received pulse yields one cell of low data to the receiver.
  wire in_rise   = serial_in & ~in_prev_q;
  assign dec_cnt_d = in_rise ? umi_pkg::UMI_IR_CELL_TICKS :
                     ((bit_x16_en && dec_cnt_q != 5'h00) ? dec_cnt_q - 5'h01 : dec_cnt_q);
  wire ir_rx     = (dec_cnt_q == 5'h00);

  always_ff @(posedge clk) begin
    if (rst) begin
      enc_cnt_q    <= 4'h0;
      tx_prev_q    <= 1'b1;
      dec_cnt_q    <= 5'h00;
      in_prev_q    <= 1'b0;
      serial_out_q <= 1'b1;
      rx_data_q    <= 1'b1;
    end else begin
      enc_cnt_q    <= enc_cnt_d;
      tx_prev_q    <= tx_data;
      dec_cnt_q    <= dec_cnt_d;
      in_prev_q    <= serial_in;
      serial_out_q <= ir_mode ? ir_pulse : tx_data;
      rx_data_q    <= ir_mode ? ir_rx : serial_in;
    end
  end

  assign serial_out = serial_out_q;
  assign rx_data    = rx_data_q;

  ir_rx_low_a: assert property (@(posedge clk) disable iff (rst)
    (ir_mode && in_rise) ##1 ir_mode |=> !rx_data)
    else $error("Infrared pulse not decoded as a low cell.");

  ir_rx_idle_a: assert property (@(posedge clk) disable iff (rst)
    (ir_mode && dec_cnt_q == 5'h00) |=> rx_data)
    else $error("Infrared decoder low without a pulse.");

  ir_tx_off_a: assert property (@(posedge clk) disable iff (rst)
    (ir_mode && tx_data) |=> !serial_out)
    else $error("Infrared output high for a one bit.");

  ir_tx_on_a: assert property (@(posedge clk) disable iff (rst)
    (ir_mode && tx_edge && !tx_data) ##1 (ir_mode && !tx_data) |=> serial_out)
    else $error("Infrared pulse missing at the start of a zero bit.");

  rts_loop_a: assert property (@(posedge clk) disable iff (rst)
    loop_mode |-> (request_to_send_n && terminal_ready_n))
    else $error("Handshake outputs active in loop mode.");

  rts_set_a: assert property (@(posedge clk) disable iff (rst)
    (wr_mctl && reg_wdata[umi_pkg::UMI_MCTL_RTS] && !reg_wdata[umi_pkg::UMI_MCTL_LOOP]) |=> !request_to_send_n)
    else $error("Request-to-send not asserted after write.");

  tready_set_a: assert property (@(posedge clk) disable iff (rst)
    (wr_mctl && reg_wdata[umi_pkg::UMI_MCTL_TREADY] && !reg_wdata[umi_pkg::UMI_MCTL_LOOP]) |=> !terminal_ready_n)
    else $error("Terminal-ready not asserted after write.");

  ctl_clear_a: assert property (@(posedge clk) disable iff (rst)
    (wr_mctl && !reg_wdata[umi_pkg::UMI_MCTL_RTS] && !reg_wdata[umi_pkg::UMI_MCTL_TREADY])
      |=> (request_to_send_n && terminal_ready_n))
    else $error("Handshake output not released after clear.");

  reset_idle_a: assert property (@(posedge clk)
    rst |=> (request_to_send_n && terminal_ready_n))
    else $error("Handshake outputs not idle after reset.");

  status_pins_a: assert property (@(posedge clk) disable iff (rst)
    rd_mstat |=> (reg_rdata[7:4] == ~$past(pins_now)))
    else $error("Status bits do not mirror inverted pins.");

  clr_delta_a: assert property (@(posedge clk) disable iff (rst)
    (clear_to_send_n != pins_q[0]) |=> delta_q[0] ##1 (reg_rdata[umi_pkg::UMI_MS_DCLR] || !$past(rd_mstat)))
    else $error("Clear-to-send delta missed.");

  setr_delta_a: assert property (@(posedge clk) disable iff (rst)
    (set_ready_n != pins_q[1]) |=> delta_q[1])
    else $error("Set-ready delta missed.");

  carr_delta_a: assert property (@(posedge clk) disable iff (rst)
    (carrier_detect_n != pins_q[3]) |=> delta_q[3])
    else $error("Carrier delta missed.");

  ring_edge_a: assert property (@(posedge clk) disable iff (rst)
    (ring_indicator_n && !pins_q[2]) |=> delta_q[2])
    else $error("Ring trailing edge missed.");

  read_clear_a: assert property (@(posedge clk) disable iff (rst)
    (rd_mstat && delta_set == 4'h0) |=> (delta_q == 4'h0 && !modem_status_irq))
    else $error("Status read did not clear deltas.");

  msirq_a: assert property (@(posedge clk) disable iff (rst)
    (ie_q[umi_pkg::UMI_IE_MSTAT] && delta_set != 4'h0 && !wr_ie) |=> modem_status_irq)
    else $error("Modem status interrupt not raised.");

  plain_tx_a: assert property (@(posedge clk) disable iff (rst)
    !ir_mode |=> (serial_out == $past(tx_data)))
    else $error("Plain transmit path broken.");

  plain_rx_a: assert property (@(posedge clk) disable iff (rst)
    !ir_mode |=> (rx_data == $past(serial_in)))
    else $error("Plain receive path broken.");

  ir_idle_a: assert property (@(posedge clk) disable iff (rst)
    (ir_mode && tx_data && $past(tx_data)) |=> !serial_out)
    else $error("Infrared output pulses on idle line.");

  rate_clk_a: assert property (@(posedge clk) disable iff (rst)
    (div_hit && !$past(rst)) |=> (serial_rate_clock_out != $past(serial_rate_clock_out)))
    else $error("Rate clock did not toggle at divider terminal count.");

endmodule // umi_modem_ir

// File: umi_pkg.sv
package umi_pkg;

  // Register map of the modem and infrared control block, byte offsets.
  localparam logic [2:0] UMI_ADDR_IE    = 3'h0;
  localparam logic [2:0] UMI_ADDR_MCTL  = 3'h1;
  localparam logic [2:0] UMI_ADDR_MSTAT = 3'h2;
  localparam logic [2:0] UMI_ADDR_IRCTL = 3'h3;
  localparam logic [2:0] UMI_ADDR_CDIV  = 3'h4;

  // Interrupt enable field.
  localparam int UMI_IE_MSTAT = 3;

  // Modem control fields.
  localparam int UMI_MCTL_TREADY = 0;
  localparam int UMI_MCTL_RTS    = 2;
  localparam int UMI_MCTL_LOOP   = 4;

  // Infrared control field.
  localparam int UMI_IRCTL_EN = 0;

  // Modem status fields.
  localparam int UMI_MS_DCLR   = 0;
  localparam int UMI_MS_DSETR  = 1;
  localparam int UMI_MS_RTRAIL = 2;
  localparam int UMI_MS_DCARR  = 3;
  localparam int UMI_MS_CLR    = 4;
  localparam int UMI_MS_SETR   = 5;
  localparam int UMI_MS_RING   = 6;
  localparam int UMI_MS_CARR   = 7;

  // Values after reset.
  localparam logic [7:0] UMI_IE_RST    = 8'h00;
  localparam logic [7:0] UMI_MCTL_RST  = 8'h00;
  localparam logic [7:0] UMI_IRCTL_RST = 8'h00;
  localparam logic [7:0] UMI_CDIV_RST  = 8'h01;
  localparam logic [7:0] UMI_RDATA_RST = 8'h00;

  // Infrared timing in ticks of the sixteen-times bit-rate enable.
  localparam logic [3:0] UMI_IR_PULSE_TICKS = 4'h3;
  localparam logic [4:0] UMI_IR_CELL_TICKS  = 5'h10;

endpackage

// File: umi_modem_model.sv
`timescale 1ns/1ps
// Modem set and infrared transceiver; it launches its lines just after an edge.
module umi_modem_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] lvl,
  input  wire logic       sin,
  output logic            clear_to_send_n,
  output logic            set_ready_n,
  output logic            ring_indicator_n,
  output logic            carrier_detect_n,
  output logic            serial_in
);
  always_ff @(posedge clk) begin
    if (rst) begin
      {carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n} <= 4'hF;
      serial_in <= 1'b1;
    end else begin
      {carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n} <= lvl;
      serial_in <= sin;
    end
  end
endmodule // umi_modem_model

// File: tb.sv
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       x16 = 1'b0;
  logic       tx = 1'b1;
  logic       sin = 1'b1;
  logic [3:0] lvl = 4'hF;
  logic [3:0] prv;
  logic [1:0] tc = 2'h0;
  logic [7:0] reg_rdata, v, e;
  logic       rx, so, rck, rts_n, trn_n, dsr_n, dcd_n, cts_n, ri_n, irq, sp;
  int         n_errors = 0;
  int         checks = 0;
  int         seed = 32'h0E6842DC;
  int         k, d;
  always #50 clk = ~clk;
  // Sparse tick so the infrared counts span several clocks.
  always @(posedge clk) begin
    tc <= tc + 2'h1;
    x16 <= (tc == 2'h3);
  end
  umi_modem_ir u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_x16_en(x16), .tx_data(tx), .rx_data(rx), .serial_out(so),
    .serial_in(sp), .serial_rate_clock_out(rck), .request_to_send_n(rts_n), .terminal_ready_n(trn_n),
    .set_ready_n(dsr_n), .carrier_detect_n(dcd_n), .clear_to_send_n(cts_n), .ring_indicator_n(ri_n),
    .modem_status_irq(irq));
  umi_modem_model u_mdm (.clk(clk), .rst(rst), .lvl(lvl), .sin(sin), .clear_to_send_n(cts_n),
    .set_ready_n(dsr_n), .ring_indicator_n(ri_n), .carrier_detect_n(dcd_n), .serial_in(sp));
  function automatic logic [7:0] stat(input logic [3:0] p, input logic [3:0] n);
    logic [3:0] c;
    c = p ^ n;
    return {~n, c[3], ~p[2] & n[2], c[1], c[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dt);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dt;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  task automatic meas(output int n);
    logic l;
    n = 0;
    l = rck;
    while (rck === l && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({6'h0, rts_n, trn_n}, 8'h03, "pins after reset");
    rd(umi_pkg::UMI_ADDR_MSTAT, v);
    chk(v, 8'h00, "idle status");
    prv = 4'hF;
    for (k = 0; k < 40; k++) begin
      v = 8'($random(seed));
      e = 8'($random(seed));
      wr(umi_pkg::UMI_ADDR_IE, v);
      wr(umi_pkg::UMI_ADDR_MCTL, e);
      chk({7'h0, rts_n}, {7'h0, ~(e[2] & ~e[4])}, "send request");
      chk({7'h0, trn_n}, {7'h0, ~(e[0] & ~e[4])}, "terminal ready");
      @(posedge clk);
      lvl <= 4'($random(seed));
      tx <= 1'($random(seed));
      sin <= 1'($random(seed));
      repeat (3) @(posedge clk);
      #1;
      chk({7'h0, so}, {7'h0, tx}, "plain tx");
      chk({7'h0, rx}, {7'h0, sin}, "plain rx");
      chk({7'h0, irq}, {7'h0, v[3] & (|(stat(prv, lvl) & 8'h0F))}, "status irq");
      rd(umi_pkg::UMI_ADDR_MSTAT, e);
      chk(e, stat(prv, lvl), "status");
      chk({7'h0, irq}, 8'h00, "irq after read");
      prv = lvl;
    end
    rd(3'h7, v);
    chk(v, 8'h00, "unmapped read");
    wr(umi_pkg::UMI_ADDR_IRCTL, 8'h01);
    tx <= 1'b1;
    sin <= 1'b0;
    repeat (80) @(posedge clk);
    #1;
    chk({6'h0, so, rx}, 8'h01, "ir idle");
    tx <= 1'b0;
    d = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      d += so;
    end
    chk({7'h0, d > 0 && d < 16 && so === 1'b0}, 8'h01, "ir pulse");
    sin <= 1'b1;
    @(posedge clk);
    sin <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({7'h0, rx}, 8'h00, "ir decode");
    repeat (80) @(posedge clk);
    #1;
    chk({7'h0, rx}, 8'h01, "ir decode end");
    for (k = 0; k < 5; k++) begin
      wr(umi_pkg::UMI_ADDR_CDIV, k[7:0]);
      meas(d);
      meas(d);
      chk(d[7:0], k[7:0] + 8'h01, "rate clock");
    end
    wr(umi_pkg::UMI_ADDR_MCTL, 8'h05);
    chk({6'h0, rts_n, trn_n}, 8'h00, "pins before reset");
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk({6'h0, rts_n, trn_n}, 8'h03, "pins in reset");
    rst <= 1'b0;
    end_sim;
  end
endmodule // tb
